/* hw/spdui_params.svh */
/*
 * constants of the speed controller front panel: timing, parameter
 * ranges, reset values and serial holding register indexes.
 * assumes a 20 MHz system clock; included by the panel modules only.
 */
`ifndef SPDUI_PARAMS_SVH
`define SPDUI_PARAMS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define SPDUI_CLK_HZ       20000000
`define SPDUI_HOLD_MS      3000
`define SPDUI_IDLE_MS      10000
`define SPDUI_DB_MS        10
`define SPDUI_BLINK_MS     100
`define SPDUI_HOLD_CYC     (`SPDUI_HOLD_MS * (`SPDUI_CLK_HZ / 1000))
`define SPDUI_IDLE_CYC     (`SPDUI_IDLE_MS * (`SPDUI_CLK_HZ / 1000))
`define SPDUI_DB_CYC       (`SPDUI_DB_MS * (`SPDUI_CLK_HZ / 1000))
`define SPDUI_BLINK_CYC    (`SPDUI_BLINK_MS * (`SPDUI_CLK_HZ / 1000))
`define SPDUI_CNT_W        28

// ----------------------------------------------------------------------
// parameter ranges and reset values (levels in percent of supply)
// ----------------------------------------------------------------------
`define SPDUI_UMIN_BASE    7'h1e
`define SPDUI_UMAX_BASE    7'h4b
`define SPDUI_U_STEP       7'h05
`define SPDUI_UMIN_MAX     4'h7
`define SPDUI_UMAX_MAX     4'h5
`define SPDUI_UMIN_RST     3'h0
`define SPDUI_UMAX_RST     3'h5
`define SPDUI_KICK_MIN     4'h3
`define SPDUI_KICK_MAX     4'h9
`define SPDUI_KICK_RST     4'h5
`define SPDUI_OVR_MIN      8'h1e
`define SPDUI_OVR_MAX      8'h64
`define SPDUI_BAUD_MAX     8'h06
`define SPDUI_BAUD_RST     3'h2
`define SPDUI_PAR_MAX      8'h02
`define SPDUI_PAR_RST      2'h1
`define SPDUI_STEP_MAX     4'h9
`define SPDUI_ITEM_MAX     3'h4

// ----------------------------------------------------------------------
// serial holding register indexes
// ----------------------------------------------------------------------
`define SPDUI_HR_UMIN      4'h0
`define SPDUI_HR_UMAX      4'h1
`define SPDUI_HR_REG       4'h2
`define SPDUI_HR_START     4'h3
`define SPDUI_HR_KICK      4'h4
`define SPDUI_HR_TERM      4'h5
`define SPDUI_HR_STATUS    4'h6
`define SPDUI_HR_BUSMODE   4'h7
`define SPDUI_HR_OVR_EN    4'h8
`define SPDUI_HR_OVR_VAL   4'h9
`define SPDUI_HR_RELAY     4'ha
`define SPDUI_HR_BAUD      4'hb
`define SPDUI_HR_PARITY    4'hc
`define SPDUI_HR_STEP      4'hd

`endif

/* hw/spdui_pkg.sv */
/*
 * types of the speed controller front panel.
 * assumes nothing of its surroundings.
 */
package spdui_pkg;

    // ------------------------------------------------------------------
    // menu states and live configuration
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SPDUI_RUN, SPDUI_LIST, SPDUI_EDIT} spdui_menu_t;

    typedef struct packed {
        logic [2:0] umin_idx;
        logic [2:0] umax_idx;
        logic       inverse;
        logic       soft_start;
        logic [3:0] kick_s;
        logic       bus_termination_resistor;
        logic       auxiliary_mains_relay;
        logic       bus_mode;
        logic       ovr_en;
        logic [6:0] ovr_val;
        logic [2:0] baud;
        logic [1:0] parity;
    } spdui_cfg_t;

    typedef struct packed {
        spdui_cfg_t  cfg;
        spdui_menu_t mstate;
        logic [2:0]  item;
        logic [3:0]  shadow;
        logic        unit_on;
        logic [3:0]  step;
        logic [27:0] hold_cnt;
        logic        hold_done;
        logic [27:0] idle_cnt;
        logic [27:0] blink_cnt;
        logic        blink_ph;
        logic [6:0]  seg;
        logic        decimal_point_marker;
        logic        pwr_led;
        logic        rx_led;
        logic        tx_led;
        logic [6:0]  level;
    } spdui_state_t;

endpackage

/* hw/spdui_debounce.sv */
/*
 * synchroniser and debouncer for the panel buttons, one lane per button.
 * assumes raw, possibly bouncing, active-high button levels.
 */
`timescale 1ns/1ns

module spdui_debounce #(
    parameter int N      = 3,
    parameter int DB_CYC = 200000
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // buttons
    input  wire logic [N-1:0] raw,
    output logic      [N-1:0] level,
    output logic      [N-1:0] press
);
    localparam int CW = $clog2(DB_CYC + 1);
    localparam logic [CW-1:0] DB_LIM = CW'(DB_CYC - 1);

    typedef struct packed {
        logic [N-1:0]         s1;
        logic [N-1:0]         s2;
        logic [N-1:0]         stable;
        logic [N-1:0]         press;
        logic [N-1:0][CW-1:0] cnt;
    } spdui_db_t;

    spdui_db_t r;
    spdui_db_t n;

    // ------------------------------------------------------------------
    // per-lane filter: a new level must hold DB_CYC cycles
    // ------------------------------------------------------------------
    always_comb begin
        n = r;
        n.s1 = raw;
        n.s2 = r.s1;
        for (int i = 0; i < N; i++) begin
            n.press[i] = 1'b0;
            if (r.s2[i] == r.stable[i]) begin
                n.cnt[i] = '0;
            end else if (r.cnt[i] >= DB_LIM) begin
                n.cnt[i] = '0;
                n.stable[i] = r.s2[i];
                n.press[i] = r.s2[i];
            end else begin
                n.cnt[i] = r.cnt[i] + CW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign level = r.stable;
    assign press = r.press;

endmodule

/* hw/spdui_panel.sv */
/*
 * front panel of a stepwise motor speed controller: buttons, menu,
 * on/off, seven-segment display, indicator leds, bus parameter writes.
 * assumes synchronous bus strobes and busy levels from the serial engine.
 */
`timescale 1ns/1ns
`include "spdui_params.svh"

module spdui_panel #(
    parameter int HOLD_CYC  = `SPDUI_HOLD_CYC,
    parameter int IDLE_CYC  = `SPDUI_IDLE_CYC,
    parameter int DB_CYC    = `SPDUI_DB_CYC,
    parameter int BLINK_CYC = `SPDUI_BLINK_CYC
) (
    // clock and reset
    input  wire logic              CLOCK,
    input  wire logic              RESET,
    // buttons, raw
    input  wire logic              BTN_UP,
    input  wire logic              BTN_DOWN,
    input  wire logic              BTN_OK,
    // serial engine
    input  wire logic              BUS_RX_ACTIVE,
    input  wire logic              BUS_TX_ACTIVE,
    input  wire logic              BUS_WR,
    input  wire logic [3:0]        BUS_IDX,
    input  wire logic [7:0]        BUS_DATA,
    // display and leds
    output logic      [6:0]        SEG,
    output logic                   SEG_DP,
    output logic                   PWR_LED,
    output logic                   RX_LED,
    output logic                   TX_LED,
    // to the controller core
    output logic                   UNIT_ON,
    output logic      [3:0]        OUT_STEP,
    output logic      [6:0]        OUT_LEVEL,
    output spdui_pkg::spdui_cfg_t  CFG
);
    import spdui_pkg::*;

    localparam logic [27:0] HOLD_LIM  = 28'(HOLD_CYC - 1);
    localparam logic [27:0] IDLE_LIM  = 28'(IDLE_CYC - 1);
    localparam logic [27:0] BLINK_LIM = 28'(BLINK_CYC - 1);
    localparam spdui_cfg_t  CFG_RST   = '{
        umin_idx: `SPDUI_UMIN_RST, umax_idx: `SPDUI_UMAX_RST,
        inverse: 1'b0, soft_start: 1'b0, kick_s: `SPDUI_KICK_RST,
        bus_termination_resistor: 1'b0, auxiliary_mains_relay: 1'b1,
        bus_mode: 1'b0, ovr_en: 1'b0, ovr_val: 7'h00,
        baud: `SPDUI_BAUD_RST, parity: `SPDUI_PAR_RST};

    spdui_state_t r;
    spdui_state_t n;
    logic [2:0]   lvl;
    logic [2:0]   prs;

    // ------------------------------------------------------------------
    // buttons: lane 0 up, lane 1 down, lane 2 ok
    // ------------------------------------------------------------------
    spdui_debounce #(
        .N      (3),
        .DB_CYC (DB_CYC)
    ) u_db (
        .clk   (CLOCK),
        .rst   (RESET),
        .raw   ({BTN_OK, BTN_DOWN, BTN_UP}),
        .level (lvl),
        .press (prs)
    );

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [6:0] seg_digit(input logic [3:0] d);
        case (d)
            4'h0: seg_digit = 7'h3f;
            4'h1: seg_digit = 7'h06;
            4'h2: seg_digit = 7'h5b;
            4'h3: seg_digit = 7'h4f;
            4'h4: seg_digit = 7'h66;
            4'h5: seg_digit = 7'h6d;
            4'h6: seg_digit = 7'h7d;
            4'h7: seg_digit = 7'h07;
            4'h8: seg_digit = 7'h7f;
            4'h9: seg_digit = 7'h6f;
            default: seg_digit = 7'h00;
        endcase
    endfunction

    // item letters: u min level, U max level, r regulation, A start, t kick
    function automatic logic [6:0] seg_letter(input logic [2:0] it);
        case (it)
            3'h0: seg_letter = 7'h1c;
            3'h1: seg_letter = 7'h3e;
            3'h2: seg_letter = 7'h50;
            3'h3: seg_letter = 7'h77;
            3'h4: seg_letter = 7'h78;
            default: seg_letter = 7'h00;
        endcase
    endfunction

    function automatic logic [3:0] item_max(input logic [2:0] it);
        case (it)
            3'h0: item_max = `SPDUI_UMIN_MAX;
            3'h1: item_max = `SPDUI_UMAX_MAX;
            3'h4: item_max = `SPDUI_KICK_MAX;
            default: item_max = 4'h1;
        endcase
    endfunction

    function automatic logic [3:0] item_min(input logic [2:0] it);
        item_min = (it == 3'h4) ? `SPDUI_KICK_MIN : 4'h0;
    endfunction

    function automatic logic [3:0] item_get(input spdui_cfg_t c, input logic [2:0] it);
        case (it)
            3'h0: item_get = {1'b0, c.umin_idx};
            3'h1: item_get = {1'b0, c.umax_idx};
            3'h2: item_get = {3'h0, c.inverse};
            3'h3: item_get = {3'h0, c.soft_start};
            default: item_get = c.kick_s;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic        up_ev;
        logic        dn_ev;
        logic        ok_ev;
        logic [6:0]  lo;
        logic [6:0]  hi;
        logic [3:0]  s;
        logic [9:0]  prod;
        logic [7:0]  d;
        up_ev = prs[0] & ~lvl[1];
        dn_ev = prs[1] & ~lvl[0];
        ok_ev = prs[2];
        d = BUS_DATA;
        n = r;

        // menu navigation
        case (r.mstate)
            SPDUI_RUN: begin
                if (r.unit_on && ok_ev) begin
                    n.mstate = SPDUI_LIST;
                    n.item = 3'h0;
                    n.idle_cnt = '0;
                end else if (r.unit_on && !r.cfg.bus_mode) begin
                    if (up_ev && r.step < `SPDUI_STEP_MAX) begin
                        n.step = r.step + 4'h1;
                    end else if (dn_ev && r.step != 4'h0) begin
                        n.step = r.step - 4'h1;
                    end
                end
            end
            SPDUI_LIST: begin
                if (ok_ev) begin
                    n.mstate = SPDUI_EDIT;
                    n.shadow = item_get(r.cfg, r.item);
                end else if (up_ev && r.item < `SPDUI_ITEM_MAX) begin
                    n.item = r.item + 3'h1;
                end else if (dn_ev && r.item != 3'h0) begin
                    n.item = r.item - 3'h1;
                end
            end
            SPDUI_EDIT: begin
                if (ok_ev) begin
                    n.mstate = SPDUI_LIST;
                    case (r.item)
                        3'h0: n.cfg.umin_idx = r.shadow[2:0];
                        3'h1: n.cfg.umax_idx = r.shadow[2:0];
                        3'h2: n.cfg.inverse = r.shadow[0];
                        3'h3: n.cfg.soft_start = r.shadow[0];
                        default: n.cfg.kick_s = r.shadow;
                    endcase
                end else if (up_ev && r.shadow < item_max(r.item)) begin
                    n.shadow = r.shadow + 4'h1;
                end else if (dn_ev && r.shadow > item_min(r.item)) begin
                    n.shadow = r.shadow - 4'h1;
                end
            end
            default: n.mstate = SPDUI_RUN;
        endcase

        // inactivity: any press restarts the wait; expiry drops the shadow
        if (r.mstate != SPDUI_RUN) begin
            if (|prs) begin
                n.idle_cnt = '0;
            end else if (r.idle_cnt >= IDLE_LIM) begin
                n.mstate = SPDUI_RUN;
                n.idle_cnt = '0;
            end else begin
                n.idle_cnt = r.idle_cnt + 28'h1;
            end
        end

        // on/off: one toggle per hold, at least one of the two buttons must be released after
        if (lvl[0] && lvl[1]) begin
            if (!r.hold_done) begin
                if (r.hold_cnt >= HOLD_LIM) begin
                    n.unit_on = ~r.unit_on;
                    n.hold_done = 1'b1;
                    n.hold_cnt = '0;
                end else begin
                    n.hold_cnt = r.hold_cnt + 28'h1;
                end
            end
        end else begin
            n.hold_cnt = '0;
            n.hold_done = 1'b0;
        end

        // bus writes; out-of-range data is ignored, bus wins over the panel
        if (BUS_WR) begin
            case (BUS_IDX)
                `SPDUI_HR_UMIN:    if (d <= 8'h07) n.cfg.umin_idx = d[2:0];
                `SPDUI_HR_UMAX:    if (d <= 8'h05) n.cfg.umax_idx = d[2:0];
                `SPDUI_HR_REG:     if (d <= 8'h01) n.cfg.inverse = d[0];
                `SPDUI_HR_START:   if (d <= 8'h01) n.cfg.soft_start = d[0];
                `SPDUI_HR_KICK:    if (d >= 8'h03 && d <= 8'h09) n.cfg.kick_s = d[3:0];
                `SPDUI_HR_TERM:    if (d <= 8'h01) n.cfg.bus_termination_resistor = d[0];
                `SPDUI_HR_STATUS:  if (d <= 8'h01) n.unit_on = d[0];
                `SPDUI_HR_BUSMODE: if (d <= 8'h01) n.cfg.bus_mode = d[0];
                `SPDUI_HR_OVR_EN:  if (d <= 8'h01) n.cfg.ovr_en = d[0];
                `SPDUI_HR_OVR_VAL: begin
                    if (d == 8'h00 || (d >= `SPDUI_OVR_MIN && d <= `SPDUI_OVR_MAX)) begin
                        n.cfg.ovr_val = d[6:0];
                    end
                end
                `SPDUI_HR_RELAY: begin
                    if (r.cfg.bus_mode && r.cfg.ovr_en && d <= 8'h01) begin
                        n.cfg.auxiliary_mains_relay = d[0];
                    end
                end
                `SPDUI_HR_BAUD:    if (d <= `SPDUI_BAUD_MAX) n.cfg.baud = d[2:0];
                `SPDUI_HR_PARITY:  if (d <= `SPDUI_PAR_MAX) n.cfg.parity = d[1:0];
                `SPDUI_HR_STEP:    if (d <= 8'h09) n.step = d[3:0];
                default: n.step = n.step;
            endcase
        end
        if (!n.unit_on) begin
            n.mstate = SPDUI_RUN;
        end

        // display, computed from the next state so it never lags
        n.decimal_point_marker = ~n.unit_on;
        if (!n.unit_on) begin
            n.seg = 7'h00;
        end else if (n.mstate == SPDUI_LIST) begin
            n.seg = seg_letter(n.item);
        end else if (n.mstate == SPDUI_EDIT) begin
            n.seg = seg_digit(n.shadow);
        end else if (n.cfg.bus_mode) begin
            n.seg = 7'h5e;
        end else begin
            n.seg = seg_digit(n.step);
        end

        // output level: proportional between min and max, or overwrite
        lo = `SPDUI_UMIN_BASE + `SPDUI_U_STEP * {4'h0, n.cfg.umin_idx};
        hi = `SPDUI_UMAX_BASE + `SPDUI_U_STEP * {4'h0, n.cfg.umax_idx};
        s = n.cfg.inverse ? (`SPDUI_STEP_MAX - n.step) : n.step;
        prod = 10'(hi - lo) * {6'h00, s};
        if (!n.unit_on) begin
            n.level = 7'h00;
        end else if (n.cfg.bus_mode && n.cfg.ovr_en) begin
            n.level = n.cfg.ovr_val;
        end else begin
            n.level = lo + 7'(prod / 10'h009);
        end

        // leds: shared blink phase gated by each busy level
        if (r.blink_cnt >= BLINK_LIM) begin
            n.blink_cnt = '0;
            n.blink_ph = ~r.blink_ph;
        end else begin
            n.blink_cnt = r.blink_cnt + 28'h1;
        end
        n.pwr_led = 1'b1;
        n.rx_led = BUS_RX_ACTIVE & r.blink_ph;
        n.tx_led = BUS_TX_ACTIVE & r.blink_ph;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            r <= '0;
            r.cfg <= CFG_RST;
            r.pwr_led <= 1'b1;
            r.decimal_point_marker <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign SEG       = r.seg;
    assign SEG_DP    = r.decimal_point_marker;
    assign PWR_LED   = r.pwr_led;
    assign RX_LED    = r.rx_led;
    assign TX_LED    = r.tx_led;
    assign UNIT_ON   = r.unit_on;
    assign OUT_STEP  = r.step;
    assign OUT_LEVEL = r.level;
    assign CFG       = r.cfg;

endmodule

/* tb/spdui_panel_sva.sv */
/*
 * port checker of the speed controller front panel.
 * assumes it is bound onto spdui_panel, one clock, synchronous reset.
 */
`timescale 1ns/1ns

module spdui_panel_sva (
    // clock and reset
    input wire logic                  CLOCK,
    input wire logic                  RESET,
    // serial engine
    input wire logic                  BUS_RX_ACTIVE,
    input wire logic                  BUS_TX_ACTIVE,
    input wire logic                  BUS_WR,
    input wire logic [3:0]            BUS_IDX,
    input wire logic [7:0]            BUS_DATA,
    // display, leds and core
    input wire logic [6:0]            SEG,
    input wire logic                  SEG_DP,
    input wire logic                  PWR_LED,
    input wire logic                  RX_LED,
    input wire logic                  TX_LED,
    input wire logic                  UNIT_ON,
    input wire logic [3:0]            OUT_STEP,
    input wire logic [6:0]            OUT_LEVEL,
    input wire spdui_pkg::spdui_cfg_t CFG
);
    import spdui_pkg::*;

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    property p_pwr; PWR_LED; endproperty
    property p_off; (SEG_DP != UNIT_ON) && (UNIT_ON || (SEG == 7'h00 && OUT_LEVEL == 7'h00));
    endproperty
    property p_rx; RX_LED |-> $past(BUS_RX_ACTIVE); endproperty
    property p_tx; TX_LED |-> $past(BUS_TX_ACTIVE); endproperty
    // phase flips every four cycles, so a busy stretch cannot leave the led frozen
    property p_blink; BUS_RX_ACTIVE [*6] |-> RX_LED != $past(RX_LED, 4); endproperty
    property p_stat; BUS_WR && BUS_IDX == 4'h6 && BUS_DATA < 8'h02
        |=> UNIT_ON == $past(BUS_DATA[0]); endproperty
    property p_ovr; BUS_WR && BUS_IDX == 4'h9 && BUS_DATA inside {[8'h01:8'h1d], [8'h65:8'hff]}
        |=> $stable(CFG.ovr_val); endproperty
    property p_relay; BUS_WR && BUS_IDX == 4'ha && !(CFG.bus_mode && CFG.ovr_en)
        |=> $stable(CFG.auxiliary_mains_relay); endproperty
    property p_lvl; UNIT_ON && $past(UNIT_ON) && OUT_STEP == 4'h0 && $stable(OUT_STEP)
        && $stable(CFG) && !CFG.inverse && !CFG.bus_mode
        |-> OUT_LEVEL == 7'h1e + 7'h05 * CFG.umin_idx; endproperty

    a_pwr:
        assert property (p_pwr) else $error("power led dark");
    a_off:
        assert property (p_off) else $error("off display or level wrong");
    a_rx:
        assert property (p_rx) else $error("receive led lit while idle");
    a_tx:
        assert property (p_tx) else $error("transmit led lit while idle");
    a_blink:
        assert property (p_blink) else $error("receive led not blinking");
    a_stat:
        assert property (p_stat) else $error("status write not taken");
    a_ovr:
        assert property (p_ovr) else $error("bad overwrite value taken");
    a_relay:
        assert property (p_relay) else $error("relay written outside overwrite mode");
    a_lvl:
        assert property (p_lvl) else $error("step zero level not the minimum");

    c_stat: cover property (BUS_WR && BUS_IDX == 4'h6);
    c_relay: cover property (BUS_WR && BUS_IDX == 4'ha && CFG.bus_mode && CFG.ovr_en);
    c_off: cover property ($fell(UNIT_ON));
endmodule

/* tb/spdui_operator.sv */
/*
 * person at the three panel buttons.
 * assumes the bench calls press; a released button reads 0.
 */
`timescale 1ns/1ns

module spdui_operator (
    // clock
    input  wire logic CLOCK,
    // buttons, pressed = 1
    output logic      btn_up,
    output logic      btn_down,
    output logic      btn_ok
);
    initial {btn_up, btn_down, btn_ok} = 3'h0;

    // b: 0 up, 1 down, 2 ok, 3 up and down together
    task automatic press(input int b, input int n);
        @(posedge CLOCK);
        {btn_up, btn_down, btn_ok} <= (b == 3) ? 3'h6 : 3'h4 >> b;
        repeat (n) @(posedge CLOCK);
        {btn_up, btn_down, btn_ok} <= 3'h0;
        // full release before the next press; end off the edge so callers read settled outputs
        repeat (8) @(negedge CLOCK);
    endtask
endmodule

/* tb/spdui_panel_tb.sv */
/*
 * self-checking bench of the front panel: bus table, reset, menu, on/off, leds.
 * assumes short counts handed to the panel through its parameters.
 */
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0h seen %0h", n, e, s); end end

module spdui_panel_tb;
    import spdui_pkg::*;
    typedef struct packed {logic [3:0] i; logic [7:0] d; logic [7:0] e;} spdui_row_t;
    localparam int IDLE = 40;
    localparam int UP = 0, DN = 1, OK = 2, BOTH = 3;
    localparam spdui_cfg_t RST_CFG = '{3'h0, 3'h5, 1'b0, 1'b0, 4'h5, 1'b0, 1'b1, 1'b0,
                                       1'b0, 7'h00, 3'h2, 2'h1};
    logic       CLOCK = 1'b0, RESET = 1'b1, BUS_RX_ACTIVE = 1'b0, BUS_TX_ACTIVE = 1'b0;
    logic       BUS_WR = 1'b0;
    logic [3:0] BUS_IDX = 4'h0;
    logic [7:0] BUS_DATA = 8'h00;
    wire logic  BTN_UP, BTN_DOWN, BTN_OK;
    logic [6:0] SEG, OUT_LEVEL;
    logic       SEG_DP, PWR_LED, RX_LED, TX_LED, UNIT_ON;
    logic [3:0] OUT_STEP;
    spdui_cfg_t CFG;
    int         n_errors = 0, compares = 0, nr, nt;
    logic [6:0] dg [10] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f,
                            7'h6f};
    spdui_row_t rows [28] = '{
        '{4'h9, 8'h1d, 8'h00}, '{4'h9, 8'h1e, 8'h1e}, '{4'h9, 8'h64, 8'h64},
        '{4'h9, 8'h65, 8'h64}, '{4'h9, 8'h00, 8'h00}, '{4'ha, 8'h00, 8'h01},
        '{4'h7, 8'h01, 8'h01}, '{4'ha, 8'h00, 8'h01}, '{4'h8, 8'h01, 8'h01},
        '{4'ha, 8'h00, 8'h00}, '{4'ha, 8'h01, 8'h01}, '{4'h4, 8'h02, 8'h05},
        '{4'h4, 8'h09, 8'h09}, '{4'h4, 8'h03, 8'h03}, '{4'hb, 8'h06, 8'h06},
        '{4'hb, 8'h07, 8'h06}, '{4'hc, 8'h02, 8'h02}, '{4'hc, 8'h03, 8'h02},
        '{4'h5, 8'h01, 8'h01}, '{4'h0, 8'h07, 8'h07}, '{4'h0, 8'h08, 8'h07},
        '{4'h1, 8'h05, 8'h05}, '{4'h1, 8'h06, 8'h05}, '{4'h2, 8'h01, 8'h01},
        '{4'h3, 8'h01, 8'h01}, '{4'h6, 8'h01, 8'h01}, '{4'hd, 8'h09, 8'h09},
        '{4'hd, 8'h0a, 8'h09}};

    always #25 CLOCK = ~CLOCK;

    spdui_operator op (.CLOCK(CLOCK), .btn_up(BTN_UP), .btn_down(BTN_DOWN), .btn_ok(BTN_OK));
    spdui_panel #(.HOLD_CYC(20), .IDLE_CYC(IDLE), .DB_CYC(3), .BLINK_CYC(4)) uut (
        .CLOCK(CLOCK), .RESET(RESET), .BTN_UP(BTN_UP), .BTN_DOWN(BTN_DOWN), .BTN_OK(BTN_OK),
        .BUS_RX_ACTIVE(BUS_RX_ACTIVE), .BUS_TX_ACTIVE(BUS_TX_ACTIVE), .BUS_WR(BUS_WR),
        .BUS_IDX(BUS_IDX), .BUS_DATA(BUS_DATA), .SEG(SEG), .SEG_DP(SEG_DP), .PWR_LED(PWR_LED),
        .RX_LED(RX_LED), .TX_LED(TX_LED), .UNIT_ON(UNIT_ON), .OUT_STEP(OUT_STEP),
        .OUT_LEVEL(OUT_LEVEL), .CFG(CFG));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] fld(input logic [3:0] i);
        case (i)
            4'h0: return {5'h00, CFG.umin_idx};
            4'h1: return {5'h00, CFG.umax_idx};
            4'h2: return {7'h00, CFG.inverse};
            4'h3: return {7'h00, CFG.soft_start};
            4'h4: return {4'h0, CFG.kick_s};
            4'h5: return {7'h00, CFG.bus_termination_resistor};
            4'h6: return {7'h00, UNIT_ON};
            4'h7: return {7'h00, CFG.bus_mode};
            4'h8: return {7'h00, CFG.ovr_en};
            4'h9: return {1'b0, CFG.ovr_val};
            4'ha: return {7'h00, CFG.auxiliary_mains_relay};
            4'hb: return {5'h00, CFG.baud};
            4'hc: return {6'h00, CFG.parity};
            default: return {4'h0, OUT_STEP};
        endcase
    endfunction

    function automatic logic [6:0] lvl(input int lo, input int hi, input int s);
        return 7'(lo + ((hi - lo) * s) / 9);
    endfunction

    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        @(posedge CLOCK);
        BUS_WR <= 1'b1;
        BUS_IDX <= i;
        BUS_DATA <= d;
        @(posedge CLOCK);
        BUS_WR <= 1'b0;
        @(negedge CLOCK);
    endtask

    task automatic rst();
        @(posedge CLOCK);
        RESET <= 1'b1;
        repeat (6) @(posedge CLOCK);
        RESET <= 1'b0;
        @(negedge CLOCK);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        rst();
        foreach (rows[k]) begin
            wr(rows[k].i, rows[k].d);
            `CHK("cfg_field", rows[k].e, fld(rows[k].i))
        end
        done("table");
        rst();
        `CHK("cfg_reset", RST_CFG, CFG)
        `CHK("dark", 9'h180, {PWR_LED, SEG_DP, SEG})
        `CHK("off", 8'h00, {UNIT_ON, OUT_LEVEL})
        done("reset");
        wr(4'h6, 8'h01);
        `CHK("step0", {dg[0], lvl(30, 100, 0)}, {SEG, OUT_LEVEL})
        wr(4'hd, 8'h09);
        `CHK("step9", {dg[9], lvl(30, 100, 9)}, {SEG, OUT_LEVEL})
        wr(4'h2, 8'h01);
        `CHK("inverse", lvl(30, 100, 0), OUT_LEVEL)
        wr(4'h2, 8'h00);
        wr(4'hd, 8'h03);
        `CHK("step3", {dg[3], lvl(30, 100, 3)}, {SEG, OUT_LEVEL})
        done("levels");
        op.press(OK, 8);
        `CHK("menu", 7'h1c, SEG)
        op.press(UP, 8);
        `CHK("next", 7'h3e, SEG)
        op.press(DN, 8);
        `CHK("prev", 7'h1c, SEG)
        op.press(UP, 8);
        op.press(OK, 8);
        `CHK("edit", dg[5], SEG)
        op.press(UP, 8);
        `CHK("saturate", dg[5], SEG)
        op.press(DN, 8);
        `CHK("shadow", {dg[4], 3'h5}, {SEG, CFG.umax_idx})
        op.press(OK, 8);
        `CHK("commit", {7'h3e, 3'h4}, {SEG, CFG.umax_idx})
        op.press(OK, 8);
        op.press(DN, 8);
        repeat (IDLE + 10) @(negedge CLOCK);
        `CHK("timeout", {dg[3], 3'h4}, {SEG, CFG.umax_idx})
        op.press(UP, 8);
        `CHK("step_up", {dg[4], lvl(30, 95, 4)}, {SEG, OUT_LEVEL})
        done("menu");
        wr(4'h7, 8'h01);
        `CHK("bus_d", 7'h5e, SEG)
        wr(4'h8, 8'h01);
        wr(4'h9, 8'h32);
        `CHK("overwrite", 7'h32, OUT_LEVEL)
        op.press(BOTH, 10);
        `CHK("short_hold", 1'b1, UNIT_ON)
        op.press(BOTH, 60);
        `CHK("toggle", 9'h080, {UNIT_ON, SEG_DP, SEG})
        done("onoff");
        for (int k = 0; k < 2; k++) begin
            nr = 0;
            nt = 0;
            @(posedge CLOCK);
            BUS_RX_ACTIVE <= (k == 0);
            BUS_TX_ACTIVE <= (k == 1);
            repeat (24) begin
                @(negedge CLOCK);
                nr += int'(RX_LED);
                nt += int'(TX_LED);
            end
            @(posedge CLOCK);
            BUS_RX_ACTIVE <= 1'b0;
            BUS_TX_ACTIVE <= 1'b0;
            `CHK("rx_blink", k == 0, nr inside {[4:20]})
            `CHK("tx_blink", k == 1, nt inside {[4:20]})
        end
        done("leds");
        conclude();
    end

    // whole run is well under 3000 cycles
    initial begin
        #250000;
        $display("watchdog expired");
        n_errors++;
        conclude();
    end
endmodule

bind spdui_panel spdui_panel_sva chk (.CLOCK(CLOCK), .RESET(RESET),
    .BUS_RX_ACTIVE(BUS_RX_ACTIVE), .BUS_TX_ACTIVE(BUS_TX_ACTIVE), .BUS_WR(BUS_WR),
    .BUS_IDX(BUS_IDX), .BUS_DATA(BUS_DATA), .SEG(SEG), .SEG_DP(SEG_DP), .PWR_LED(PWR_LED),
    .RX_LED(RX_LED), .TX_LED(TX_LED), .UNIT_ON(UNIT_ON), .OUT_STEP(OUT_STEP),
    .OUT_LEVEL(OUT_LEVEL), .CFG(CFG));
